/* File: hdl/plc_cell.v */
// Configurable logic cell: two sum-of-products arrays and a byte datapath
//
// Contract
// RULE1 - Two independent sum-of-products arrays sit beside the datapath.
// RULE2 - Array inputs from routing; outputs registered or combinational.
// RULE3 - Each array has 12 inputs shared by eight product terms.
// RULE4 - Each term ANDs 1 to 12 inputs, true or inverted per input.
// RULE5 - Each output ORs a programmable choice of up to 8 terms.
// RULE6 - Every output OR gate has the same eight-term width.
// RULE7 - Any array input or output is interchangeable with any other.
// RULE8 - Eight-bit ALU, one operation per clock, with compare and conditions.
// RULE9 - Conditions: two compares, two zero, two all-ones, one overflow.
// RULE10 - Configuration store of eight 16-bit words selects each operation.
// RULE11 - Accumulators are ALU sources, ALU destinations and compare sources.
// RULE12 - Operand registers feed ALU and compares, never written by ALU.
// RULE13 - Each of two byte queues holds up to four entries.
// RULE14 - Queues load operands or accumulators; capture accumulator or ALU.
// RULE15 - Bus reads and writes all six working registers during operation; an input queue reads as zero and an output queue drops bus writes.
// RULE16 - Bus reaches every datapath register, configuration store included.
// RULE17 - Store address comes from routed inputs, changing every cycle.
// RULE18 - ALU: inc, dec, add, sub, and, or, xor, pass; shift, swap, mask.
// RULE19 - Each queue is either bus-written input or bus-read output buffer.
// RULE20 - Registered state updates on the cell clock, cleared by reset.
`timescale 1ns/1ps
`include "plc_map.vh"

module plc_cell (
  // Clock and reset
  input wire SYS_CLK,
  input wire NRST,
  // System bus register port
  input wire BUS_WR,
  input wire BUS_RD,
  input wire [7:0] BUS_ADDR,
  input wire [7:0] BUS_WDATA,
  output reg [7:0] BUS_RDATA,
  // Logic array routing
  input wire [11:0] PLA0_IN,
  input wire [11:0] PLA1_IN,
  output reg [3:0] PLA0_OUT,
  output reg [3:0] PLA1_OUT,
  // Datapath routing
  input wire [2:0] CFG_SEL,
  input wire SHIFT_IN,
  output reg SHIFT_OUT,
  output reg [6:0] COND,
  output reg [3:0] QUE_FLAGS
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [7:0] acc0, acc1, opr0, opr1, mask, qctl, cctl;
  reg [7:0] store [0:`PLC_STORE_BYTES-1];
  reg [7:0] pla_cfg [0:2*`PLC_PLA_BYTES-1];
  reg [3:0] pla_q0, pla_q1;
  integer i;

  wire bus_acc0 = BUS_ADDR == `PLC_ADDR_ACC0;
  wire bus_acc1 = BUS_ADDR == `PLC_ADDR_ACC1;
  wire bus_opr0 = BUS_ADDR == `PLC_ADDR_OPR0;
  wire bus_opr1 = BUS_ADDR == `PLC_ADDR_OPR1;
  wire bus_que0 = BUS_ADDR == `PLC_ADDR_QUE0;
  wire bus_que1 = BUS_ADDR == `PLC_ADDR_QUE1;
  wire bus_store = BUS_ADDR[7:4] == `PLC_ADDR_STORE >> 4;
  wire bus_pla = (BUS_ADDR[7:6] == 2'h1 || BUS_ADDR[7:6] == 2'h2) &&
                 BUS_ADDR[5:0] < `PLC_PLA_BYTES;
  wire [6:0] pla_idx = BUS_ADDR[7] ? BUS_ADDR[6:0] - 7'h58 :
                                     BUS_ADDR[6:0] - 7'h40;

  // ----------------------------------------------------------------
  // Sum-of-products arrays
  // ----------------------------------------------------------------
  // Term is live only if at least one literal is enabled
  function pterm;
    input [11:0] in;
    input [11:0] t_en;
    input [11:0] c_en;
    begin
      pterm = (|(t_en | c_en)) & (&(~t_en | in)) & // RULE4
              (&(~c_en | ~in));
    end
  endfunction

  wire [23:0] pla_in = {PLA1_IN, PLA0_IN};
  wire [15:0] term;
  wire [7:0] sop;

  genvar p, t, o;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_pla // RULE1
      for (t = 0; t < 8; t = t + 1) begin : g_term
        // Every term sees all 12 inputs
        assign term[p*8+t] = pterm(pla_in[p*12 +: 12], // RULE3
          {pla_cfg[p*40+t*4+1][3:0], pla_cfg[p*40+t*4]},
          {pla_cfg[p*40+t*4+3][3:0], pla_cfg[p*40+t*4+2]});
      end
      for (o = 0; o < 4; o = o + 1) begin : g_out
        // Same eight-wide OR per output keeps outputs swappable
        assign sop[p*4+o] = |(term[p*8 +: 8] & // RULE5 RULE6 RULE7
                              pla_cfg[p*40+`PLC_PLA_OR_BASE+o]);
      end
    end
  endgenerate

  // Combinational mode bypasses the flop; output mux is unavoidable here
  always @* begin
    PLA0_OUT = (pla_q0 & pla_cfg[`PLC_PLA_REG_SEL][3:0]) |
               (sop[3:0] & ~pla_cfg[`PLC_PLA_REG_SEL][3:0]); // RULE2
    PLA1_OUT = (pla_q1 & pla_cfg[`PLC_PLA_BYTES+`PLC_PLA_REG_SEL][3:0]) |
               (sop[7:4] & ~pla_cfg[`PLC_PLA_BYTES+`PLC_PLA_REG_SEL][3:0]);
  end

  // ----------------------------------------------------------------
  // Configuration word and ALU
  // ----------------------------------------------------------------
  wire [15:0] cw = {store[{CFG_SEL, 1'b1}], // RULE17 RULE10
                    store[{CFG_SEL, 1'b0}]};
  wire [7:0] op_a = cw[`PLC_CW_SRCA] ? acc1 : acc0; // RULE11
  reg [7:0] op_b;
  reg [8:0] alu;
  reg ovf;
  reg [7:0] shifted;
  reg next_so;
  wire [7:0] alu_out = cw[`PLC_CW_MASK_EN] ? (shifted | mask) : shifted;

  always @* begin
    case (cw[`PLC_CW_SRCB])
      2'h0: op_b = opr0; // RULE12
      2'h1: op_b = opr1;
      2'h2: op_b = acc0;
      default: op_b = acc1;
    endcase
  end

  always @* begin
    ovf = 1'b0;
    case (cw[`PLC_CW_FUNC]) // RULE8 RULE18
      `PLC_FN_INC: begin
        alu = {1'b0, op_a} + 9'h001;
        ovf = op_a == 8'h7f;
      end
      `PLC_FN_DEC: begin
        alu = {1'b0, op_a} - 9'h001;
        ovf = op_a == 8'h80;
      end
      `PLC_FN_ADD: begin
        alu = {1'b0, op_a} + {1'b0, op_b};
        ovf = (op_a[7] == op_b[7]) && (alu[7] != op_a[7]);
      end
      `PLC_FN_SUB: begin
        alu = {1'b0, op_a} - {1'b0, op_b};
        ovf = (op_a[7] != op_b[7]) && (alu[7] != op_a[7]);
      end
      `PLC_FN_AND: alu = {1'b0, op_a & op_b};
      `PLC_FN_OR: alu = {1'b0, op_a | op_b};
      `PLC_FN_XOR: alu = {1'b0, op_a ^ op_b};
      default: alu = {1'b0, op_a};
    endcase
  end

  always @* begin
    next_so = 1'b0;
    case (cw[`PLC_CW_SHIFT]) // RULE18
      `PLC_SH_LEFT: begin
        shifted = {alu[6:0], SHIFT_IN};
        next_so = alu[7];
      end
      `PLC_SH_RIGHT: begin
        shifted = {SHIFT_IN, alu[7:1]};
        next_so = alu[0];
      end
      `PLC_SH_SWAP: shifted = {alu[3:0], alu[7:4]};
      default: shifted = alu[7:0];
    endcase
  end

  // ----------------------------------------------------------------
  // Byte queues
  // ----------------------------------------------------------------
  wire [15:0] que_head;
  wire [1:0] que_empty, que_full;
  wire [1:0] que_dir = {qctl[`PLC_QCTL_DIR1], qctl[`PLC_QCTL_DIR0]};
  wire [1:0] bus_que_wr = {BUS_WR & bus_que1, BUS_WR & bus_que0};
  wire [1:0] bus_que_rd = {BUS_RD & bus_que1, BUS_RD & bus_que0};
  wire [1:0] int_pop = {
    cw[`PLC_CW_OPR1_LD] | (cw[`PLC_CW_ACC1_WR] == `PLC_AW_QUE),
    cw[`PLC_CW_OPR0_LD] | (cw[`PLC_CW_ACC0_WR] == `PLC_AW_QUE)};
  wire [1:0] que_take = ~que_dir & int_pop & ~que_empty;
  wire [7:0] cap0 = qctl[`PLC_QCTL_SRC0] ? alu_out : acc0;
  wire [7:0] cap1 = qctl[`PLC_QCTL_SRC1] ? alu_out : acc1;

  generate
    for (p = 0; p < 2; p = p + 1) begin : g_que
      reg [7:0] mem [0:`PLC_QUE_DEPTH-1]; // RULE13
      reg [1:0] wp, rp;
      reg [2:0] cnt;
      integer j;
      // Direction picks which side pushes and which side pops
      wire push = (que_dir[p] ? cw[`PLC_CW_CAPTURE] : bus_que_wr[p]) & // RULE19
                  ~que_full[p];
      wire pop = (que_dir[p] ? bus_que_rd[p] : que_take[p]) & ~que_empty[p];
      wire [7:0] din = que_dir[p] ? (p ? cap1 : cap0) : BUS_WDATA; // RULE14
      assign que_head[p*8 +: 8] = mem[rp];
      assign que_empty[p] = cnt == 3'h0;
      assign que_full[p] = cnt == `PLC_QUE_DEPTH;
      always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
          wp <= 2'h0; // RULE20
          rp <= 2'h0;
          cnt <= 3'h0;
          for (j = 0; j < `PLC_QUE_DEPTH; j = j + 1)
            mem[j] <= `PLC_RST_BYTE;
        end else begin
          if (push) begin
            mem[wp] <= din;
            wp <= wp + 2'h1;
          end
          if (pop)
            rp <= rp + 2'h1;
          if (push && !pop)
            cnt <= cnt + 3'h1;
          else if (pop && !push)
            cnt <= cnt - 3'h1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Conditions
  // ----------------------------------------------------------------
  wire [7:0] cmp1_a = cctl[`PLC_CCTL_ACC1] ? acc0 : acc1;
  wire cmp0 = cctl[`PLC_CCTL_LESS0] ? acc0 < opr0 : acc0 == opr0;
  wire cmp1 = cctl[`PLC_CCTL_LESS1] ? cmp1_a < opr1 : cmp1_a == opr1;

  // ----------------------------------------------------------------
  // Working registers, bus port and outputs
  // ----------------------------------------------------------------
  reg [7:0] next_rdata;

  always @* begin
    next_rdata = 8'h00;
    if (bus_acc0) next_rdata = acc0; // RULE15
    else if (bus_acc1) next_rdata = acc1;
    else if (bus_opr0) next_rdata = opr0;
    else if (bus_opr1) next_rdata = opr1;
    else if (bus_que0) next_rdata = que_dir[0] ? que_head[7:0] : 8'h00;
    else if (bus_que1) next_rdata = que_dir[1] ? que_head[15:8] : 8'h00;
    else if (BUS_ADDR == `PLC_ADDR_QCTL) next_rdata = {4'h0, qctl[3:0]};
    else if (BUS_ADDR == `PLC_ADDR_QSTAT)
      next_rdata = {4'h0, que_full[1], que_empty[1],
                    que_full[0], que_empty[0]};
    else if (BUS_ADDR == `PLC_ADDR_MASK) next_rdata = mask;
    else if (BUS_ADDR == `PLC_ADDR_CCTL) next_rdata = {5'h00, cctl[2:0]};
    else if (bus_store) next_rdata = store[BUS_ADDR[3:0]]; // RULE16
    else if (bus_pla) next_rdata = pla_cfg[pla_idx];
  end

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      acc0 <= `PLC_RST_BYTE; // RULE20
      acc1 <= `PLC_RST_BYTE;
      opr0 <= `PLC_RST_BYTE;
      opr1 <= `PLC_RST_BYTE;
      mask <= `PLC_RST_BYTE;
      qctl <= `PLC_RST_BYTE;
      cctl <= `PLC_RST_BYTE;
      for (i = 0; i < `PLC_STORE_BYTES; i = i + 1)
        store[i] <= `PLC_RST_BYTE;
      for (i = 0; i < 2*`PLC_PLA_BYTES; i = i + 1)
        pla_cfg[i] <= `PLC_RST_BYTE;
      pla_q0 <= 4'h0;
      pla_q1 <= 4'h0;
      BUS_RDATA <= `PLC_RST_BYTE;
      SHIFT_OUT <= 1'b0;
      COND <= 7'h00;
      QUE_FLAGS <= 4'h0;
    end else begin
      pla_q0 <= sop[3:0]; // RULE2
      pla_q1 <= sop[7:4];
      // Datapath writes; a bus write in the same cycle wins below
      case (cw[`PLC_CW_ACC0_WR]) // RULE11 RULE14
        `PLC_AW_ALU: acc0 <= alu_out;
        `PLC_AW_QUE: if (que_take[0]) acc0 <= que_head[7:0];
        default: acc0 <= acc0;
      endcase
      case (cw[`PLC_CW_ACC1_WR])
        `PLC_AW_ALU: acc1 <= alu_out;
        `PLC_AW_QUE: if (que_take[1]) acc1 <= que_head[15:8];
        default: acc1 <= acc1;
      endcase
      if (cw[`PLC_CW_OPR0_LD] && que_take[0]) opr0 <= que_head[7:0]; // RULE12
      if (cw[`PLC_CW_OPR1_LD] && que_take[1]) opr1 <= que_head[15:8];
      if (BUS_WR) begin
        if (bus_acc0) acc0 <= BUS_WDATA; // RULE15
        if (bus_acc1) acc1 <= BUS_WDATA;
        if (bus_opr0) opr0 <= BUS_WDATA;
        if (bus_opr1) opr1 <= BUS_WDATA;
        if (BUS_ADDR == `PLC_ADDR_QCTL) qctl <= BUS_WDATA;
        if (BUS_ADDR == `PLC_ADDR_MASK) mask <= BUS_WDATA;
        if (BUS_ADDR == `PLC_ADDR_CCTL) cctl <= BUS_WDATA;
        if (bus_store) store[BUS_ADDR[3:0]] <= BUS_WDATA; // RULE16
        if (bus_pla) pla_cfg[pla_idx] <= BUS_WDATA;
      end
      if (BUS_RD)
        BUS_RDATA <= next_rdata;
      SHIFT_OUT <= next_so;
      // Conditions lag the registers by one clock
      COND <= {ovf, &acc1, &acc0, acc1 == 8'h00, acc0 == 8'h00, // RULE9
               cmp1, cmp0};
      QUE_FLAGS <= {que_full[1], que_empty[1], que_full[0], que_empty[0]};
    end
  end

endmodule // plc_cell

/* File: include/plc_map.vh */
// Register map, field layout and reset values of the logic datapath cell
`ifndef PLC_MAP_VH
`define PLC_MAP_VH

// ----------------------------------------------------------------
// Register addresses (byte wide, 8-bit address)
// ----------------------------------------------------------------
`define PLC_ADDR_ACC0 8'h00
`define PLC_ADDR_ACC1 8'h01
`define PLC_ADDR_OPR0 8'h02
`define PLC_ADDR_OPR1 8'h03
`define PLC_ADDR_QUE0 8'h04
`define PLC_ADDR_QUE1 8'h05
`define PLC_ADDR_QCTL 8'h06
`define PLC_ADDR_QSTAT 8'h07
`define PLC_ADDR_MASK 8'h08
`define PLC_ADDR_CCTL 8'h09
`define PLC_ADDR_STORE 8'h10
`define PLC_ADDR_PLA0 8'h40
`define PLC_ADDR_PLA1 8'h80

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define PLC_STORE_BYTES 16
`define PLC_PLA_BYTES 40
`define PLC_PLA_OR_BASE 32
`define PLC_PLA_REG_SEL 36
`define PLC_QUE_DEPTH 4

// ----------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------
`define PLC_CW_FUNC 2:0
`define PLC_CW_SRCA 3
`define PLC_CW_SRCB 5:4
`define PLC_CW_SHIFT 7:6
`define PLC_CW_MASK_EN 8
`define PLC_CW_ACC0_WR 10:9
`define PLC_CW_ACC1_WR 12:11
`define PLC_CW_OPR0_LD 13
`define PLC_CW_OPR1_LD 14
`define PLC_CW_CAPTURE 15

// ALU functions
`define PLC_FN_INC 3'h0
`define PLC_FN_DEC 3'h1
`define PLC_FN_ADD 3'h2
`define PLC_FN_SUB 3'h3
`define PLC_FN_AND 3'h4
`define PLC_FN_OR 3'h5
`define PLC_FN_XOR 3'h6
`define PLC_FN_PASS 3'h7

// Shifter modes
`define PLC_SH_NONE 2'h0
`define PLC_SH_LEFT 2'h1
`define PLC_SH_RIGHT 2'h2
`define PLC_SH_SWAP 2'h3

// Accumulator write sources
`define PLC_AW_HOLD 2'h0
`define PLC_AW_ALU 2'h1
`define PLC_AW_QUE 2'h2

// Queue control bits: direction (1 = output) and capture source (1 = ALU)
`define PLC_QCTL_DIR0 0
`define PLC_QCTL_DIR1 1
`define PLC_QCTL_SRC0 2
`define PLC_QCTL_SRC1 3

// Compare control bits
`define PLC_CCTL_LESS0 0
`define PLC_CCTL_LESS1 1
`define PLC_CCTL_ACC1 2

// Reset values
`define PLC_RST_BYTE 8'h00
`define PLC_RST_WORD 16'h0000

`endif

/* File: tb/plc_cell_asserts.sv */
// Port-level concurrent checks for the logic datapath cell
`timescale 1ns/1ps
module plc_cell_asserts (
  // Clock and reset
  input wire SYS_CLK,
  input wire NRST,
  // Register bus
  input wire BUS_WR,
  input wire BUS_RD,
  input wire [7:0] BUS_ADDR,
  input wire [7:0] BUS_WDATA,
  input wire [7:0] BUS_RDATA,
  // Routing outputs
  input wire [3:0] PLA0_OUT,
  input wire [3:0] PLA1_OUT,
  input wire [6:0] COND,
  input wire [3:0] QUE_FLAGS
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  wire hole = (BUS_ADDR > 8'h09 && BUS_ADDR < 8'h10) ||
    (BUS_ADDR > 8'h1f && BUS_ADDR < 8'h40) ||
    (BUS_ADDR > 8'h67 && BUS_ADDR < 8'h80) || BUS_ADDR > 8'ha7;
  // The mask and the store are untouched by the datapath
  wire plain = BUS_ADDR == 8'h08 || (BUS_ADDR > 8'h0f && BUS_ADDR < 8'h20);
  reg pla_set;
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      pla_set <= 1'b0;
    end else if (BUS_WR && BUS_ADDR[7:6] != 2'h0) begin
      pla_set <= 1'b1;
    end
  end
  property p_rdata_hold;
    !BUS_RD |=> $stable(BUS_RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  property p_unmapped;
    BUS_RD && hole |=> BUS_RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_readback;
    BUS_WR && plain ##1 !BUS_WR ##1 BUS_RD && !BUS_WR &&
      BUS_ADDR == $past(BUS_ADDR, 2) |=> BUS_RDATA == $past(BUS_WDATA, 3);
  endproperty
  a_readback: assert property (p_readback)
    else $error("store readback differs from write");
  property p_q0_sane;
    !(QUE_FLAGS[0] && QUE_FLAGS[1]);
  endproperty
  a_q0_sane: assert property (p_q0_sane)
    else $error("queue zero full and empty");
  property p_q1_sane;
    !(QUE_FLAGS[2] && QUE_FLAGS[3]);
  endproperty
  a_q1_sane: assert property (p_q1_sane)
    else $error("queue one full and empty");
  property p_acc_flags;
    !(COND[2] && COND[4]) && !(COND[3] && COND[5]);
  endproperty
  a_acc_flags: assert property (p_acc_flags)
    else $error("zero and all-ones both set");
  property p_pla_idle;
    !pla_set |-> PLA0_OUT == 4'h0 && PLA1_OUT == 4'h0;
  endproperty
  a_pla_idle: assert property (p_pla_idle)
    else $error("array output without any term");
  property p_after_reset;
    $rose(NRST) && !BUS_WR |=> QUE_FLAGS == 4'h5 && COND == 7'h0f;
  endproperty
  a_after_reset: assert property (p_after_reset)
    else $error("state after reset wrong");
  c_readback: cover property (BUS_WR && plain ##2 BUS_RD);
  c_unmapped: cover property (BUS_RD && hole);
  c_q0_full: cover property (QUE_FLAGS[1]);
endmodule // plc_cell_asserts
bind plc_cell plc_cell_asserts i_plc_cell_asserts (.SYS_CLK(SYS_CLK),
  .NRST(NRST), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_ADDR(BUS_ADDR),
  .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA), .PLA0_OUT(PLA0_OUT),
  .PLA1_OUT(PLA1_OUT), .COND(COND), .QUE_FLAGS(QUE_FLAGS));

/* File: tb/plc_bus_host.sv */
// Processor and DMA side model driving the register bus
`timescale 1ns/1ps
module plc_bus_host (
  // Clock
  input wire clk,
  // Register bus
  output logic bus_wr,
  output logic bus_rd,
  output logic [7:0] bus_addr,
  output logic [7:0] bus_wdata,
  input wire [7:0] bus_rdata
);
  initial begin
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
  end
  // Called at a falling edge; strobe spans one rising edge, then one idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    d = bus_rdata;
    @(negedge clk);
  endtask
endmodule // plc_bus_host

/* File: tb/test_plc_cell.sv */
// Self-checking bench of the logic datapath cell
`timescale 1ns/1ps
`include "plc_map.vh"
`define CHK(w, e, g) begin n_compared++; if ((g) !== (e)) begin \
  num_errors++; $display("BAD %s exp %h got %h", w, e, g); end end
module test_plc_cell;
  logic SYS_CLK = 1'b0;
  logic NRST = 1'b0;
  logic [2:0] CFG_SEL = 3'h0;
  logic SHIFT_IN = 1'b0;
  logic [11:0] PLA0_IN = 12'h000;
  logic [11:0] PLA1_IN = 12'h000;
  logic BUS_WR, BUS_RD, SHIFT_OUT;
  logic [7:0] BUS_ADDR, BUS_WDATA, BUS_RDATA;
  logic [3:0] PLA0_OUT, PLA1_OUT, QUE_FLAGS;
  logic [6:0] COND;
  logic [7:0] lfsr = 8'h2f;
  logic [7:0] a, b, v;
  logic so, ov;
  logic [7:0] q [5];
  int num_errors = 0;
  int n_compared = 0;
  initial begin
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  plc_cell i_plc_cell (.SYS_CLK(SYS_CLK), .NRST(NRST), .BUS_WR(BUS_WR),
    .BUS_RD(BUS_RD), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA),
    .BUS_RDATA(BUS_RDATA), .PLA0_IN(PLA0_IN), .PLA1_IN(PLA1_IN),
    .PLA0_OUT(PLA0_OUT), .PLA1_OUT(PLA1_OUT), .CFG_SEL(CFG_SEL),
    .SHIFT_IN(SHIFT_IN), .SHIFT_OUT(SHIFT_OUT), .COND(COND),
    .QUE_FLAGS(QUE_FLAGS));
  plc_bus_host i_plc_bus_host (.clk(SYS_CLK), .bus_wr(BUS_WR),
    .bus_rd(BUS_RD), .bus_addr(BUS_ADDR), .bus_wdata(BUS_WDATA),
    .bus_rdata(BUS_RDATA));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction
  function automatic logic [7:0] alu(logic [2:0] f, logic [7:0] x, y);
    case (f)
      3'h0: return x + 8'h01;
      3'h1: return x - 8'h01;
      3'h2: return x + y;
      3'h3: return x - y;
      3'h4: return x & y;
      3'h5: return x | y;
      3'h6: return x ^ y;
      default: return x;
    endcase
  endfunction
  // Signed overflow of the arithmetic functions, zero for the rest
  function automatic logic exp_ov(logic [2:0] f, logic [7:0] x, y);
    logic [7:0] r;
    r = alu(f, x, y);
    case (f)
      3'h0: return x == 8'h7f;
      3'h1: return x == 8'h80;
      3'h2: return x[7] == y[7] && r[7] != x[7];
      3'h3: return x[7] != y[7] && r[7] != x[7];
      default: return 1'b0;
    endcase
  endfunction
  // Word 1 carries the operation; word 0 stays all-zero so the cell idles
  task automatic run_op(input logic [15:0] w, input logic [7:0] e);
    i_plc_bus_host.wr(8'h12, w[7:0]);
    i_plc_bus_host.wr(8'h13, w[15:8]);
    CFG_SEL = 3'h1;
    @(negedge SYS_CLK);
    so = SHIFT_OUT;
    ov = COND[6];
    CFG_SEL = 3'h0;
    i_plc_bus_host.rd(`PLC_ADDR_ACC0, v);
    `CHK("acc0", e, v)
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (10) @(negedge SYS_CLK);
    NRST = 1'b1;
    @(negedge SYS_CLK);
    `CHK("flags", 4'h5, QUE_FLAGS)
    `CHK("cond", 7'h0f, COND)
    $display("reset test done");
    for (int r = 0; r < 26; r++) begin
      b = (r < 4) ? r[7:0] : (r < 10) ? 8'h08 : r[7:0] + 8'h06;
      a = rnd();
      i_plc_bus_host.wr(b, a);
      i_plc_bus_host.rd(b, v);
      `CHK("reg", a, v)
    end
    // Word 0 back to all-zero so the datapath idles again
    i_plc_bus_host.wr(8'h10, 8'h00);
    i_plc_bus_host.wr(8'h11, 8'h00);
    i_plc_bus_host.rd(8'h0a, v);
    `CHK("hole", 8'h00, v)
    $display("register test done");
    for (int k = 0; k < 5; k++) begin
      q[k] = rnd();
      i_plc_bus_host.wr(`PLC_ADDR_QUE0, q[k]);
    end
    @(negedge SYS_CLK);
    `CHK("full", 4'h6, QUE_FLAGS)
    i_plc_bus_host.rd(`PLC_ADDR_QUE0, v);
    `CHK("input queue read", 8'h00, v)
    for (int k = 0; k < 5; k++) begin
      run_op(16'h0400, q[k > 3 ? 3 : k]);
    end
    `CHK("empty", 4'h5, QUE_FLAGS)
    $display("queue test done");
    for (int f = 0; f < 8; f++) begin
      a = rnd();
      b = rnd();
      i_plc_bus_host.wr(`PLC_ADDR_ACC0, a);
      i_plc_bus_host.wr(`PLC_ADDR_OPR0, b);
      run_op({7'h01, 1'b0, 5'h00, f[2:0]}, alu(f[2:0], a, b));
      `CHK("ovf", exp_ov(f[2:0], a, b), ov)
    end
    for (int s = 1; s < 4; s++) begin
      a = rnd();
      SHIFT_IN = a[0];
      i_plc_bus_host.wr(`PLC_ADDR_ACC0, a);
      v = s == 1 ? {a[6:0], a[0]} :
          s == 2 ? {a[0], a[7:1]} : {a[3:0], a[7:4]};
      run_op({7'h01, 1'b0, s[1:0], 6'h24}, v);
      `CHK("shift out", s == 1 ? a[7] : s == 2 ? a[0] : 1'b0, so)
    end
    i_plc_bus_host.wr(`PLC_ADDR_MASK, b);
    run_op({7'h01, 1'b1, 8'h24}, v | b);
    i_plc_bus_host.rd(`PLC_ADDR_OPR0, v);
    `CHK("opr0 kept", b, v)
    i_plc_bus_host.wr(`PLC_ADDR_ACC0, 8'hff);
    i_plc_bus_host.wr(`PLC_ADDR_OPR0, 8'hff);
    repeat (2) @(negedge SYS_CLK);
    `CHK("cmp0 and ones", 2'h3, {COND[0], COND[4]})
    $display("alu test done");
    i_plc_bus_host.wr(8'h40, 8'h01);
    i_plc_bus_host.wr(8'h46, 8'h02);
    i_plc_bus_host.wr(8'h60, 8'h01);
    i_plc_bus_host.wr(8'h61, 8'h02);
    for (int k = 0; k < 8; k++) begin
      a = rnd();
      PLA0_IN = {a[3:0], rnd()};
      a = rnd();
      PLA1_IN = {a[3:0], rnd()};
      #5;
      `CHK("pla0", {2'h0, ~PLA0_IN[1], PLA0_IN[0]}, PLA0_OUT)
      `CHK("pla1", 4'h0, PLA1_OUT)
      @(negedge SYS_CLK);
    end
    i_plc_bus_host.wr(8'h64, 8'h01);
    PLA0_IN = 12'h001;
    @(negedge SYS_CLK);
    PLA0_IN = 12'h000;
    #5;
    `CHK("registered out", 1'b1, PLA0_OUT[0])
    $display("array test done");
    end_sim();
  end
endmodule // test_plc_cell
